/* common/dac_host_if_defines.svh */
// Constants for the DAC host interface front end
`ifndef DAC_HOST_IF_DEFINES_SVH
`define DAC_HOST_IF_DEFINES_SVH
`define DATA_W         14
`define ADDR_W         8
`define SER_WORD_W     24
`define REF_CLK_HZ     10000000
`define SCLK_MAX_HZ    50000000
`define REGSEL_INPUT   2'h3
`define REGSEL_OFFSET  2'h2
`define REGSEL_GAIN    2'h1
`define REGSEL_SPECIAL 2'h0
`define MODE_SETTLE    2'h3
`define PIN_IDLE_HI    1'h1
`define PIN_IDLE_LO    1'h0
`endif

/* common/dac_host_if_pkg.sv */
// Types for the DAC host interface front end
package dac_host_if_pkg;
  typedef enum logic [1:0] {
    DEST_SPECIAL,
    DEST_GAIN,
    DEST_OFFSET,
    DEST_INPUT
  } dest_t;

  typedef struct packed {
    logic [7:0]  addr;
    dest_t       dest;
    logic [13:0] data;
  } par_word_t;
endpackage : dac_host_if_pkg

/* core/dac_host_interface_select.sv */
// Host front end: strap-selected serial or parallel write port
`include "dac_host_if_defines.svh"

module dac_host_interface_select #(
  parameter int SER_WORD_W = `SER_WORD_W
) (
  // Clock and reset
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst_n,
  // Mode straps
  input  wire logic                         i_interface_select,
  input  wire logic                         i_chain_enable,
  // Serial port
  input  wire logic                         i_sync_n,
  input  wire logic                         i_sclk,
  input  wire logic                         i_sdin,
  output logic                              o_serial_data_out,
  // Parallel port
  input  wire logic                         i_cs_n,
  input  wire logic                         i_wr_n,
  input  wire logic [`ADDR_W-1:0]           i_addr,
  input  wire logic                         i_reg_select_lo,
  input  wire logic                         i_reg_select_hi,
  input  wire logic [`DATA_W-1:0]           i_data,
  // Decoded outputs
  output logic                              o_serial_mode,
  output logic                              o_chain_mode,
  output logic                              o_ser_valid,
  output logic [SER_WORD_W-1:0]             o_ser_word,
  output logic                              o_par_valid,
  output dac_host_if_pkg::par_word_t        o_par_word
);

  // Seven single pins, two register selects, address and data
  localparam int SYNC_W = 9 + `ADDR_W + `DATA_W;
  localparam int CNT_W  = $clog2(SER_WORD_W + 1);
  // Ref clock samples sclk; edges faster than a quarter of it are lost
  localparam int SCLK_SAMPLED_MAX_HZ = `REF_CLK_HZ / 4;
  // Idle pin levels, so no false strobe edge follows reset
  localparam logic [SYNC_W-1:0] PINS_IDLE = {`PIN_IDLE_LO, `PIN_IDLE_LO, `PIN_IDLE_HI,
                                             `PIN_IDLE_LO, `PIN_IDLE_LO, `PIN_IDLE_HI,
                                             `PIN_IDLE_HI,
                                             {(`ADDR_W + 2 + `DATA_W){`PIN_IDLE_LO}}};

  if (SER_WORD_W < 2 || SER_WORD_W > 64 || SCLK_SAMPLED_MAX_HZ < 1) begin : g_bad_param
    $error("SER_WORD_W out of range");
  end

  // Two-stage synchroniser for every pin
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] pins;
  assign pins = {i_interface_select, i_chain_enable, i_sync_n, i_sclk, i_sdin,
                 i_cs_n, i_wr_n, i_addr, i_reg_select_hi, i_reg_select_lo, i_data};

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= PINS_IDLE;
      sync_q <= PINS_IDLE;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  logic              s_sel;
  logic              s_chain;
  logic              s_sync_n;
  logic              s_sclk;
  logic              s_sdin;
  logic              s_cs_n;
  logic              s_wr_n;
  logic [`ADDR_W-1:0] s_addr;
  logic [1:0]        s_regsel;
  logic [`DATA_W-1:0] s_data;
  assign {s_sel, s_chain, s_sync_n, s_sclk, s_sdin, s_cs_n, s_wr_n, s_addr,
          s_regsel, s_data} = sync_q;

  function automatic dac_host_if_pkg::dest_t decode_dest(input logic [1:0] sel);
    if (sel == `REGSEL_INPUT) begin
      decode_dest = dac_host_if_pkg::DEST_INPUT;
    end else if (sel == `REGSEL_OFFSET) begin
      decode_dest = dac_host_if_pkg::DEST_OFFSET;
    end else if (sel == `REGSEL_GAIN) begin
      decode_dest = dac_host_if_pkg::DEST_GAIN;
    end else begin
      decode_dest = dac_host_if_pkg::DEST_SPECIAL;
    end
  endfunction : decode_dest

  // Mode follows the strap until the synchroniser has filled, then holds
  logic       mode_q;
  logic       mode_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic       chain_q;
  logic       chain_d;

  always_comb begin
    settle_d = settle_q;
    if (settle_q != `MODE_SETTLE) begin
      settle_d = settle_q + 2'h1;
    end
    mode_d  = (settle_q == `MODE_SETTLE) ? mode_q : s_sel;
    chain_d = s_chain && mode_d;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_q <= 2'h0;
      mode_q   <= 1'b0;
      chain_q  <= 1'b0;
    end else begin
      settle_q <= settle_d;
      mode_q   <= mode_d;
      chain_q  <= chain_d;
    end
  end

  // Serial shift register
  logic                  sclk_q;
  logic                  sclk_d;
  logic [SER_WORD_W-1:0] shift_q;
  logic [SER_WORD_W-1:0] shift_d;
  logic [CNT_W-1:0]      cnt_q;
  logic [CNT_W-1:0]      cnt_d;
  logic                  sdo_q;
  logic                  sdo_d;
  logic                  sync_prev_q;
  logic                  sync_prev_d;
  logic                  ser_valid_q;
  logic                  ser_valid_d;
  logic [SER_WORD_W-1:0] ser_word_q;
  logic [SER_WORD_W-1:0] ser_word_d;

  always_comb begin
    sclk_d      = s_sclk;
    sync_prev_d = s_sync_n;
    shift_d     = shift_q;
    cnt_d       = cnt_q;
    sdo_d       = sdo_q;
    ser_valid_d = 1'b0;
    ser_word_d  = ser_word_q;
    if (mode_q && !s_sync_n) begin
      if (sclk_q && !s_sclk) begin
        shift_d = {shift_q[SER_WORD_W-2:0], s_sdin};
        if (cnt_q != CNT_W'(SER_WORD_W)) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end else if (!sclk_q && s_sclk && chain_q) begin
        sdo_d = shift_q[SER_WORD_W-1];
      end
    end
    if (mode_q && s_sync_n && !sync_prev_q) begin
      if (chain_q || cnt_q == CNT_W'(SER_WORD_W)) begin
        ser_valid_d = 1'b1;
        ser_word_d  = shift_q;
      end
      cnt_d = '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q      <= 1'b0;
      sync_prev_q <= 1'b1;
      shift_q     <= '0;
      cnt_q       <= '0;
      sdo_q       <= 1'b0;
      ser_valid_q <= 1'b0;
      ser_word_q  <= '0;
    end else begin
      sclk_q      <= sclk_d;
      sync_prev_q <= sync_prev_d;
      shift_q     <= shift_d;
      cnt_q       <= cnt_d;
      sdo_q       <= sdo_d;
      ser_valid_q <= ser_valid_d;
      ser_word_q  <= ser_word_d;
    end
  end

  // Parallel write port
  logic                       wr_prev_q;
  logic                       wr_prev_d;
  logic                       par_valid_q;
  logic                       par_valid_d;
  dac_host_if_pkg::par_word_t par_word_q;
  dac_host_if_pkg::par_word_t par_word_d;

  always_comb begin
    wr_prev_d   = s_wr_n;
    par_valid_d = 1'b0;
    par_word_d  = par_word_q;
    if (!mode_q && !s_cs_n && !wr_prev_q && s_wr_n) begin
      par_valid_d     = 1'b1;
      par_word_d.addr = s_addr;
      par_word_d.dest = decode_dest(s_regsel);
      par_word_d.data = s_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_prev_q   <= 1'b1;
      par_valid_q <= 1'b0;
      par_word_q  <= '0;
    end else begin
      wr_prev_q   <= wr_prev_d;
      par_valid_q <= par_valid_d;
      par_word_q  <= par_word_d;
    end
  end

  assign o_serial_mode     = mode_q;
  assign o_chain_mode      = chain_q;
  assign o_serial_data_out = sdo_q;
  assign o_ser_valid       = ser_valid_q;
  assign o_ser_word        = ser_word_q;
  assign o_par_valid       = par_valid_q;
  assign o_par_word        = par_word_q;

endmodule : dac_host_interface_select

/* bench/dac_host_sva.sv */
// Assertion checker for the DAC host interface front end
module dac_host_sva #(
  parameter int SER_WORD_W = 24
) (
  // Inputs
  input wire logic                       i_ref_clk,
  input wire logic                       i_rst_n,
  input wire logic                       i_sync_n,
  input wire logic                       i_sclk,
  input wire logic                       i_cs_n,
  input wire logic                       i_wr_n,
  input wire logic [7:0]                 i_addr,
  input wire logic                       i_reg_select_lo,
  input wire logic                       i_reg_select_hi,
  input wire logic [13:0]                i_data,
  // Outputs
  input wire logic                       o_serial_data_out,
  input wire logic                       o_serial_mode,
  input wire logic                       o_chain_mode,
  input wire logic                       o_ser_valid,
  input wire logic                       o_par_valid,
  input wire dac_host_if_pkg::par_word_t o_par_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence wr_taken;
    $rose(i_wr_n) && !i_cs_n && !o_serial_mode;
  endsequence
  chk_par_write: assert property (wr_taken |-> ##[1:6] o_par_valid)
    else $error("parallel write not delivered");
  chk_par_select: assert property (o_par_valid |-> !$past(i_cs_n, 3) && !o_serial_mode)
    else $error("parallel word without select");
  chk_par_fields: assert property (o_par_valid |->
    o_par_word == {i_addr, i_reg_select_hi, i_reg_select_lo, i_data})
    else $error("parallel word fields wrong");
  chk_ser_mode: assert property (o_ser_valid |-> o_serial_mode)
    else $error("serial word in parallel mode");
  chk_chain_mode: assert property (o_chain_mode |-> o_serial_mode)
    else $error("chain mode without serial mode");
  chk_sdo_held: assert property (!o_chain_mode |=> $stable(o_serial_data_out))
    else $error("serial out moved outside chain mode");
  chk_sdo_idle: assert property (i_sync_n [*6] |-> $stable(o_serial_data_out))
    else $error("serial out moved outside frame");
  chk_sdo_rise: assert property ($changed(o_serial_data_out) |-> $past(i_sclk, 3))
    else $error("serial out moved away from rising clock");
endmodule : dac_host_sva

bind dac_host_interface_select dac_host_sva #(.SER_WORD_W(SER_WORD_W)) u_sva (
  .i_ref_clk         (i_ref_clk),
  .i_rst_n           (i_rst_n),
  .i_sync_n          (i_sync_n),
  .i_sclk            (i_sclk),
  .i_cs_n            (i_cs_n),
  .i_wr_n            (i_wr_n),
  .i_addr            (i_addr),
  .i_reg_select_lo   (i_reg_select_lo),
  .i_reg_select_hi   (i_reg_select_hi),
  .i_data            (i_data),
  .o_serial_data_out (o_serial_data_out),
  .o_serial_mode     (o_serial_mode),
  .o_chain_mode      (o_chain_mode),
  .o_ser_valid       (o_ser_valid),
  .o_par_valid       (o_par_valid),
  .o_par_word        (o_par_word)
);

/* bench/dac_host_model.sv */
// Host model driving the serial port
module dac_host_model (
  // Serial port
  output logic        o_sync_n,
  output logic        o_sclk,
  output logic        o_sdin,
  input  wire logic   i_sdo,
  // Bits seen on the chain output
  output logic [23:0] o_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_sync_n = 1'b1;
    o_sclk = 1'b0;
    o_sdin = 1'b0;
    o_seen = 24'h000000;
  end
  task frame(input logic [23:0] w, input logic framed);
    #37 o_sync_n = !framed;
    #400;
    for (int i = 23; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_sdin = w[i];
      #400 o_sclk = 1'b0;
      #200 o_seen = {o_seen[22:0], i_sdo};
      #200;
    end
    #400 o_sync_n = 1'b1;
    o_sdin = !o_sdin;
  endtask : frame
endmodule : dac_host_model

/* bench/dac_host_interface_select_test.sv */
// Self-checking bench for the DAC host interface front end
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module dac_host_interface_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 0, i_rst_n = 0, i_interface_select = 0, i_chain_enable = 0;
  logic i_cs_n = 1, i_wr_n = 1, i_reg_select_lo = 0, i_reg_select_hi = 0;
  logic [7:0]  i_addr = 8'h00;
  logic [13:0] i_data = 14'h0000;
  wire logic i_sync_n, i_sclk, i_sdin, o_serial_data_out, o_serial_mode;
  wire logic o_chain_mode, o_ser_valid, o_par_valid;
  wire logic [23:0] o_ser_word;
  wire dac_host_if_pkg::par_word_t o_par_word;
  logic [23:0] exp_q[$];
  logic [23:0] seen, w, e, a;
  int seed = 32'h200f8ffe;
  int checked = 0, miscompares = 0;
  logic mode_exp = 0;
  dac_host_interface_select u_dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_interface_select(i_interface_select),
    .i_chain_enable(i_chain_enable), .i_sync_n(i_sync_n), .i_sclk(i_sclk), .i_sdin(i_sdin),
    .o_serial_data_out(o_serial_data_out), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n),
    .i_addr(i_addr), .i_reg_select_lo(i_reg_select_lo), .i_reg_select_hi(i_reg_select_hi),
    .i_data(i_data), .o_serial_mode(o_serial_mode), .o_chain_mode(o_chain_mode),
    .o_ser_valid(o_ser_valid), .o_ser_word(o_ser_word), .o_par_valid(o_par_valid),
    .o_par_word(o_par_word));
  dac_host_model u_host (.o_sync_n(i_sync_n), .o_sclk(i_sclk), .o_sdin(i_sdin),
    .i_sdo(o_serial_data_out), .o_seen(seen));
  always #50 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (o_ser_valid | o_par_valid) begin
    if (exp_q.size() == 0) `CHK("stray", 1'b0, 1'b1)
    else begin
      e = exp_q.pop_front();
      `CHK("word", e, o_ser_valid ? o_ser_word : o_par_word)
    end
  end
  task end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task rst(input logic sel, input logic ce);
    @(posedge i_ref_clk) #1 i_rst_n = 0;
    i_interface_select = sel;
    i_chain_enable = ce;
    mode_exp = sel;
    repeat (3) @(posedge i_ref_clk);
    #1 i_rst_n = 1;
    `CHK("early mode", 1'b0, o_serial_mode)
    repeat (5) @(posedge i_ref_clk);
    #1 `CHK("mode", sel, o_serial_mode)
    `CHK("chain", sel & ce, o_chain_mode)
  endtask : rst
  task par(input logic cs, input logic [1:0] sel);
    @(posedge i_ref_clk) #1 w = 24'($random(seed));
    w[15:14] = sel;
    {i_addr, i_reg_select_hi, i_reg_select_lo, i_data} = w;
    i_cs_n = cs;
    i_wr_n = 0;
    if (!cs && !mode_exp) exp_q.push_back(w);
    repeat (3) @(posedge i_ref_clk);
    #1 i_wr_n = 1;
    repeat (6) @(posedge i_ref_clk);
    #1 i_cs_n = 1;
  endtask : par
  task ser(input logic framed);
    w = 24'($random(seed));
    u_host.frame(w, framed);
    if (framed && mode_exp) exp_q.push_back(w);
    repeat (10) @(posedge i_ref_clk);
  endtask : ser
  initial begin
    #3ms miscompares++;
    end_of_test;
  end
  initial begin
    rst(1'b0, 1'b1);
    for (int k = 0; k < 4; k++) par(1'b0, k[1:0]);
    par(1'b1, 2'h3);
    ser(1'b1);
    rst(1'b1, 1'b0);
    ser(1'b1);
    ser(1'b0);
    par(1'b0, 2'h3);
    rst(1'b1, 1'b1);
    ser(1'b1);
    a = w;
    ser(1'b1);
    `CHK("chain out", a, seen)
    `CHK("pending", 0, exp_q.size())
    end_of_test;
  end
endmodule : dac_host_interface_select_test
